// ---- design/sadp_defs.svh ----
// Register indices, reset values, field positions and timing counts
`ifndef SADP_DEFS_SVH
`define SADP_DEFS_SVH
`define SADP_IDX_PORTCTL 16'hff91
`define SADP_IDX_MODE 16'hffa8
`define SADP_IDX_BAUD 16'hffa9
`define SADP_IDX_CTRL 16'hffaa
`define SADP_IDX_TXH 16'hffab
`define SADP_IDX_STAT 16'hffac
`define SADP_IDX_RXH 16'hffad
`define SADP_IDX_CKGATE 16'hfffa
`define SADP_IDX_IRQST 16'hffb0
`define SADP_IDX_IRQMSK 16'hffb1
`define SADP_RST_PORTCTL 8'hc0
`define SADP_RST_MODE 8'h00
`define SADP_RST_BAUD 8'hff
`define SADP_RST_CTRL 8'h00
`define SADP_RST_TXH 8'hff
`define SADP_RST_STAT 8'h84
`define SADP_RST_RXH 8'h00
`define SADP_RST_CKGATE 8'hff
`define SADP_CTRL_TE 5
`define SADP_CTRL_RE 4
`define SADP_CTRL_CKE1 1
`define SADP_ST_TX_EMPTY_FLAG 7
`define SADP_ST_RDRF 6
`define SADP_ST_OER 5
`define SADP_ST_FER 4
`define SADP_ST_PER 3
`define SADP_ST_TEND 2
`define SADP_CKGATE_BIT 5
`define SADP_IRQ_TX_EMPTY_FLAG 0
`define SADP_IRQ_RDRF 1
`define SADP_IRQ_OER 2
`define SADP_IRQ_FER 3
`define SADP_IRQ_PER 4
`define SADP_IRQ_TEND 5
`define SADP_OVS_LAST 4'hf
`define SADP_OVS_MID 4'h7
`endif

// ---- design/sadp_pkg.sv ----
// Types shared by the serial data path
package sadp_pkg;
  typedef struct packed {
    logic com;
    logic chr;
    logic pe;
    logic pm;
    logic stop;
    logic mp;
    logic [1:0] cks;
  } sadp_mode_s;
  typedef enum logic [4:0] {
    SADP_IDLE = 5'h01,
    SADP_START = 5'h02,
    SADP_DATA = 5'h04,
    SADP_PAR = 5'h08,
    SADP_STOP = 5'h10
  } sadp_state_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
  } sadp_apb_req_s;
endpackage : sadp_pkg

// ---- design/sadp_top.sv ----
// Serial unit data path: shifters, holding registers, mode select, APB slave
// Overview of operation
// - Receive pin bits enter rx_shifter lsb first and build a byte.
// - A finished byte moves to rx_holding with no software action.
// - rx_shifter and rx_holding double buffer so reception continues.
// - rx_holding is 8 bits and read only; writes leave it unchanged.
// - rx_holding clears to 00 on reset, standby and module standby.
// - tx_shifter loads from tx_holding and drives the tx pin lsb first.
// - After a byte the next one loads and starts, never while empty flag is 1.
// - Neither shifter can be read or written by software.
// - An empty tx_shifter takes the pending byte; early writes give back to back.
// - tx_holding is 8 bits, resets to ff on reset and standby, RW except in standby or module standby.
// - The mode register clears to 00 on reset and standby entry.
// - The mode register is readable at any time and writable except in standby or module standby.
// - Mode bit 7 selects asynchronous (0) or clocked synchronous (1).
// - Async length is 8 or 7 bits by char_length_select; sync is always 8.
// - Reception checks only the first stop bit; a following 0 is a start.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "sadp_defs.svh"
`default_nettype none
module sadp_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire sadp_pkg::sadp_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power control
  input wire logic standby_req,
  // Serial pins
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // Interrupt
  output logic irq
);
  import sadp_pkg::*;

  logic [7:0] serial_port_control;
  sadp_mode_s serial_mode_format;
  logic [7:0] baud_divisor;
  logic [7:0] serial_control;
  logic [7:0] tx_holding;
  logic [7:0] serial_status;
  logic [7:0] rx_holding;
  logic [7:0] module_clock_gate_1;
  logic [5:0] irq_status;
  logic [5:0] irq_mask;
  logic [7:0] rx_shifter;
  logic [7:0] tx_shifter;

  // Bus decode
  logic acc, done, wr_done;
  logic [15:0] idx;
  logic [7:0] wd;
  logic [7:0] rd_mux;
  logic rd_hit;
  assign acc = apb_req.psel & apb_req.penable;
  assign done = acc & pready;
  assign wr_done = done & apb_req.pwrite & ~pslverr;
  assign idx = apb_req.paddr[17:2];
  assign wd = apb_req.pwdata[7:0];

  // Shifters are absent from the map on purpose
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 8'h00;
    unique case (idx)
      `SADP_IDX_PORTCTL: rd_mux = serial_port_control;
      `SADP_IDX_MODE: rd_mux = serial_mode_format;
      `SADP_IDX_BAUD: rd_mux = baud_divisor;
      `SADP_IDX_CTRL: rd_mux = serial_control;
      `SADP_IDX_TXH: rd_mux = tx_holding;
      `SADP_IDX_STAT: rd_mux = serial_status;
      `SADP_IDX_RXH: rd_mux = rx_holding;
      `SADP_IDX_CKGATE: rd_mux = module_clock_gate_1;
      `SADP_IDX_IRQST: rd_mux = {2'b00, irq_status};
      `SADP_IDX_IRQMSK: rd_mux = {2'b00, irq_mask};
      default: rd_hit = 1'b0;
    endcase
  end

  // One wait state; data and error captured before completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      if (acc & ~pready) begin
        prdata <= {24'h00_0000, rd_mux};
        pslverr <= ~rd_hit;
      end
    end
  end

  function automatic logic wr_to(input logic [15:0] i);
    wr_to = wr_done && idx == i;
  endfunction

  // Standby or gated module clock puts the unit in its initial state
  logic init;
  assign init = standby_req | ~module_clock_gate_1[`SADP_CKGATE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_port_control <= `SADP_RST_PORTCTL;
      baud_divisor <= `SADP_RST_BAUD;
      module_clock_gate_1 <= `SADP_RST_CKGATE;
      irq_mask <= 6'h00;
    end else begin
      if (wr_to(`SADP_IDX_PORTCTL)) serial_port_control <= wd;
      if (wr_to(`SADP_IDX_BAUD)) baud_divisor <= wd;
      if (wr_to(`SADP_IDX_CKGATE)) module_clock_gate_1 <= wd;
      if (wr_to(`SADP_IDX_IRQMSK)) irq_mask <= wd[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_format <= `SADP_RST_MODE;
      serial_control <= `SADP_RST_CTRL;
    end else if (init) begin
      serial_mode_format <= `SADP_RST_MODE;
      serial_control <= `SADP_RST_CTRL;
    end else begin
      if (wr_to(`SADP_IDX_MODE)) serial_mode_format <= wd;
      if (wr_to(`SADP_IDX_CTRL)) serial_control <= wd;
    end
  end

  logic sync_mode, te, re, ext_clk, len8;
  assign sync_mode = serial_mode_format.com;
  assign te = serial_control[`SADP_CTRL_TE];
  assign re = serial_control[`SADP_CTRL_RE];
  assign ext_clk = serial_control[`SADP_CTRL_CKE1];
  assign len8 = sync_mode | ~serial_mode_format.chr;

  // Pin synchronisers
  logic [1:0] rx_sync;
  logic [2:0] sck_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync <= 2'b11;
      sck_sync <= 3'b111;
    end else begin
      rx_sync <= {rx_sync[0], serial_rx_pin};
      sck_sync <= {sck_sync[1:0], serial_clock_pin_in};
    end
  end
  logic rx_s;
  assign rx_s = rx_sync[1];

  // Prescaler and divisor give a 16x oversample tick
  logic [6:0] pre_cnt, pre_lim;
  logic [7:0] baud_counter;
  logic pre_tick, tick;
  always_comb begin
    unique case (serial_mode_format.cks)
      2'b00: pre_lim = 7'h00;
      2'b01: pre_lim = 7'h01;
      2'b10: pre_lim = 7'h0f;
      2'b11: pre_lim = 7'h3f;
    endcase
  end
  assign pre_tick = pre_cnt >= pre_lim;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 7'h00;
      baud_counter <= 8'h00;
      tick <= 1'b0;
    end else begin
      pre_cnt <= pre_tick ? 7'h00 : pre_cnt + 7'h01;
      tick <= 1'b0;
      if (pre_tick) begin
        if (baud_counter >= baud_divisor) begin
          baud_counter <= 8'h00;
          tick <= 1'b1;
        end else begin
          baud_counter <= baud_counter + 8'h01;
        end
      end
    end
  end

  // Synchronous clock: internal half bit is 8 ticks, idles high
  logic [2:0] half_cnt;
  logic int_fall, int_rise, ext_fall, ext_rise, sclk_fall, sclk_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt <= 3'h0;
      serial_clock_pin_out <= 1'b1;
      serial_clock_pin_oe <= 1'b0;
      int_fall <= 1'b0;
      int_rise <= 1'b0;
    end else begin
      serial_clock_pin_oe <= sync_mode & ~ext_clk;
      int_fall <= 1'b0;
      int_rise <= 1'b0;
      if (!(sync_mode & ~ext_clk & (te | re))) begin
        half_cnt <= 3'h0;
        serial_clock_pin_out <= 1'b1;
      end else if (tick) begin
        half_cnt <= half_cnt + 3'h1;
        if (half_cnt == 3'h7) begin
          serial_clock_pin_out <= ~serial_clock_pin_out;
          int_fall <= serial_clock_pin_out;
          int_rise <= ~serial_clock_pin_out;
        end
      end
    end
  end
  assign ext_fall = sck_sync[2] & ~sck_sync[1];
  assign ext_rise = ~sck_sync[2] & sck_sync[1];
  assign sclk_fall = ext_clk ? ext_fall : int_fall;
  assign sclk_rise = ext_clk ? ext_rise : int_rise;

  // Transmitter
  sadp_state_e tx_st;
  logic [3:0] tx_cnt;
  logic [2:0] tx_bitn;
  logic tx_par, tx_stop2, tx_load;
  logic tx_tick_end, tx_last, tx_empty_flag, tx_more;
  assign tx_empty_flag = serial_status[`SADP_ST_TX_EMPTY_FLAG];
  assign tx_tick_end = tick && tx_cnt == `SADP_OVS_LAST;
  assign tx_last = tx_bitn == (len8 ? 3'h7 : 3'h6);
  assign tx_more = te & ~tx_empty_flag;
  logic tx_end_ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= SADP_IDLE;
      tx_cnt <= 4'h0;
      tx_bitn <= 3'h0;
      tx_shifter <= 8'hff;
      tx_par <= 1'b0;
      tx_stop2 <= 1'b0;
      serial_tx_pin <= 1'b1;
      tx_load <= 1'b0;
      tx_end_ev <= 1'b0;
    end else begin
      tx_load <= 1'b0;
      tx_end_ev <= 1'b0;
      if (tick) tx_cnt <= tx_cnt + 4'h1;
      if (init | ~te) begin
        tx_st <= SADP_IDLE;
        serial_tx_pin <= 1'b1;
      end else if (sync_mode) begin
        // Bits change on the falling clock edge
        if (sclk_fall) begin
          if ((tx_st == SADP_IDLE || tx_last) && tx_more) begin
            serial_tx_pin <= tx_holding[0];
            tx_shifter <= {1'b1, tx_holding[7:1]};
            tx_bitn <= 3'h0;
            tx_load <= 1'b1;
            tx_st <= SADP_DATA;
          end else if (tx_st == SADP_DATA && tx_last) begin
            serial_tx_pin <= 1'b1;
            tx_end_ev <= 1'b1;
            tx_st <= SADP_IDLE;
          end else if (tx_st == SADP_DATA) begin
            serial_tx_pin <= tx_shifter[0];
            tx_shifter <= {1'b1, tx_shifter[7:1]};
            tx_bitn <= tx_bitn + 3'h1;
          end
        end
      end else begin
        unique case (tx_st)
          SADP_IDLE: if (tx_more) begin
            tx_shifter <= tx_holding;
            tx_load <= 1'b1;
            tx_cnt <= 4'h0;
            serial_tx_pin <= 1'b0;
            tx_st <= SADP_START;
          end
          SADP_START, SADP_DATA: if (tx_tick_end) begin
            if (tx_st == SADP_DATA && tx_last) begin
              serial_tx_pin <= serial_mode_format.pe ? tx_par ^ serial_mode_format.pm : 1'b1;
              tx_stop2 <= serial_mode_format.stop;
              tx_st <= serial_mode_format.pe ? SADP_PAR : SADP_STOP;
            end else begin
              serial_tx_pin <= tx_shifter[0];
              tx_par <= (tx_st == SADP_START ? 1'b0 : tx_par) ^ tx_shifter[0];
              tx_shifter <= {1'b1, tx_shifter[7:1]};
              tx_bitn <= tx_st == SADP_START ? 3'h0 : tx_bitn + 3'h1;
              tx_st <= SADP_DATA;
            end
          end
          SADP_PAR: if (tx_tick_end) begin
            serial_tx_pin <= 1'b1;
            tx_st <= SADP_STOP;
          end
          SADP_STOP: if (tx_tick_end) begin
            if (tx_stop2) begin
              tx_stop2 <= 1'b0;
            end else if (tx_more) begin
              // Back to back: next start bit follows the stop bit
              tx_shifter <= tx_holding;
              tx_load <= 1'b1;
              serial_tx_pin <= 1'b0;
              tx_st <= SADP_START;
            end else begin
              tx_end_ev <= 1'b1;
              tx_st <= SADP_IDLE;
            end
          end
          default: tx_st <= SADP_IDLE;
        endcase
      end
    end
  end

  // Receiver
  sadp_state_e rx_st;
  logic [3:0] rx_cnt;
  logic [2:0] rx_bitn;
  logic rx_par, rx_per, rx_done, rx_fer;
  logic rx_mid, rx_last;
  logic [7:0] rx_byte;
  assign rx_mid = tick && rx_cnt == `SADP_OVS_LAST;
  assign rx_last = rx_bitn == (len8 ? 3'h7 : 3'h6);
  assign rx_byte = len8 ? rx_shifter : {1'b0, rx_shifter[7:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= SADP_IDLE;
      rx_cnt <= 4'h0;
      rx_bitn <= 3'h0;
      rx_shifter <= 8'h00;
      rx_par <= 1'b0;
      rx_per <= 1'b0;
      rx_fer <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) rx_cnt <= rx_cnt + 4'h1;
      if (init | ~re) begin
        rx_st <= SADP_IDLE;
      end else if (sync_mode) begin
        rx_per <= 1'b0;
        rx_fer <= 1'b0;
        if (rx_st != SADP_DATA) begin
          rx_st <= SADP_DATA;
          rx_bitn <= 3'h0;
        end else if (sclk_rise) begin
          rx_shifter <= {rx_s, rx_shifter[7:1]};
          rx_bitn <= rx_bitn + 3'h1;
          rx_done <= rx_bitn == 3'h7;
        end
      end else begin
        unique case (rx_st)
          SADP_IDLE: if (!rx_s) begin
            rx_cnt <= 4'h0;
            rx_st <= SADP_START;
          end
          SADP_START: if (tick && rx_cnt == `SADP_OVS_MID) begin
            // A glitch shorter than half a bit is not a start
            rx_cnt <= 4'h0;
            rx_bitn <= 3'h0;
            rx_par <= 1'b0;
            rx_st <= rx_s ? SADP_IDLE : SADP_DATA;
          end
          SADP_DATA: if (rx_mid) begin
            rx_shifter <= {rx_s, rx_shifter[7:1]};
            rx_par <= rx_par ^ rx_s;
            rx_bitn <= rx_bitn + 3'h1;
            if (rx_last) rx_st <= serial_mode_format.pe ? SADP_PAR : SADP_STOP;
          end
          SADP_PAR: if (rx_mid) begin
            rx_par <= rx_par ^ rx_s;
            rx_st <= SADP_STOP;
          end
          SADP_STOP: if (rx_mid) begin
            // Only the first stop bit is looked at
            rx_per <= serial_mode_format.pe & (rx_par ^ serial_mode_format.pm);
            rx_fer <= ~rx_s;
            rx_done <= 1'b1;
            rx_st <= SADP_IDLE;
          end
          default: rx_st <= SADP_IDLE;
        endcase
      end
    end
  end

  // Byte moves to the holding register unless the last one is unread
  logic rdrf, rx_take;
  assign rdrf = serial_status[`SADP_ST_RDRF];
  assign rx_take = rx_done & ~rdrf;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_holding <= `SADP_RST_RXH;
      tx_holding <= `SADP_RST_TXH;
    end else if (init) begin
      rx_holding <= `SADP_RST_RXH;
      tx_holding <= `SADP_RST_TXH;
    end else begin
      // rx_holding takes no bus writes
      if (rx_take) rx_holding <= rx_byte;
      if (wr_to(`SADP_IDX_TXH)) tx_holding <= wd;
    end
  end

  // Status flags: hardware set wins over a software clear
  logic [5:0] ev;
  logic [7:0] st_clr, st_set;
  assign ev[`SADP_IRQ_TX_EMPTY_FLAG] = tx_load;
  assign ev[`SADP_IRQ_RDRF] = rx_take;
  assign ev[`SADP_IRQ_OER] = rx_done & rdrf;
  assign ev[`SADP_IRQ_FER] = rx_take & rx_fer;
  assign ev[`SADP_IRQ_PER] = rx_take & rx_per;
  assign ev[`SADP_IRQ_TEND] = tx_end_ev;
  always_comb begin
    st_clr = 8'h00;
    st_set = 8'h00;
    if (wr_to(`SADP_IDX_STAT)) st_clr[6:3] = ~wd[6:3];
    if (wr_to(`SADP_IDX_TXH)) begin
      st_clr[`SADP_ST_TX_EMPTY_FLAG] = 1'b1;
      st_clr[`SADP_ST_TEND] = 1'b1;
    end
    st_set[`SADP_ST_TX_EMPTY_FLAG] = ev[`SADP_IRQ_TX_EMPTY_FLAG];
    st_set[`SADP_ST_RDRF] = ev[`SADP_IRQ_RDRF];
    st_set[`SADP_ST_OER] = ev[`SADP_IRQ_OER];
    st_set[`SADP_ST_FER] = ev[`SADP_IRQ_FER];
    st_set[`SADP_ST_PER] = ev[`SADP_IRQ_PER];
    st_set[`SADP_ST_TEND] = ev[`SADP_IRQ_TEND];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_status <= `SADP_RST_STAT;
    end else if (init) begin
      serial_status <= `SADP_RST_STAT;
    end else begin
      serial_status <= (serial_status & ~st_clr) | st_set;
    end
  end

  // Sticky events; a read clears only the bits it returned
  logic [5:0] irq_clr;
  assign irq_clr = (done && !apb_req.pwrite && idx == `SADP_IDX_IRQST) ? prdata[5:0] : 6'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 6'h00;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | ev;
      irq <= |(((irq_status & ~irq_clr) | ev) & irq_mask);
    end
  end
endmodule : sadp_top
`default_nettype wire

// ---- verification/sadp_top_props.sv ----
// Checker for bus answers, read-only and standby behaviour of the serial data path
`timescale 1ns/1ps
`include "sadp_defs.svh"
`default_nettype none
module sadp_top_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire sadp_pkg::sadp_apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and power
  input wire logic standby_req,
  input wire logic serial_rx_pin,
  input wire logic serial_tx_pin,
  input wire logic serial_clock_pin_in,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic irq
);
  import sadp_pkg::*;
  logic [15:0] idx;
  logic rd;
  assign idx = apb_req.paddr[17:2];
  assign rd = pready && !apb_req.pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_wait: assert property (
    apb_req.psel && apb_req.penable && !pready |-> ##[1:2] pready) else $error("pready late");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("pready held too long");
  a_err_map: assert property (
    pready |-> pslverr == !(idx inside {`SADP_IDX_PORTCTL, `SADP_IDX_MODE, `SADP_IDX_BAUD,
    `SADP_IDX_CTRL, `SADP_IDX_TXH, `SADP_IDX_STAT, `SADP_IDX_RXH, `SADP_IDX_CKGATE,
    `SADP_IDX_IRQST, `SADP_IDX_IRQMSK})) else $error("pslverr wrong for address");
  a_rx_write_ok: assert property (
    pready && apb_req.pwrite && idx == `SADP_IDX_RXH |-> !pslverr) else $error("rx write error");
  a_read_width: assert property (
    rd |-> prdata[31:8] == 24'h0) else $error("read upper bits set");
  a_rx_standby: assert property (
    rd && idx == `SADP_IDX_RXH && standby_req && $past(standby_req, 2) |-> prdata == 32'h0)
    else $error("rx holding not cleared in standby");
  a_tx_standby: assert property (
    rd && idx == `SADP_IDX_TXH && standby_req && $past(standby_req, 2) |-> prdata == 32'hff)
    else $error("tx holding not set in standby");
  a_mode_standby: assert property (
    rd && idx == `SADP_IDX_MODE && standby_req && $past(standby_req, 2) |-> prdata == 32'h0)
    else $error("mode not cleared in standby");
  a_tx_quiet: assert property (
    standby_req [*3] |-> serial_tx_pin) else $error("tx pin active in standby");
endmodule : sadp_top_props
bind sadp_top sadp_top_props i_sadp_top_props (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .standby_req(standby_req), .serial_rx_pin(serial_rx_pin),
  .serial_tx_pin(serial_tx_pin), .serial_clock_pin_in(serial_clock_pin_in),
  .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
  .irq(irq)
);
`default_nettype wire

// ---- verification/sadp_uart_peer.sv ----
// Remote serial partner: async sender and monitor, clocked sync exchange
`timescale 1ns/1ps
`default_nettype none
module sadp_uart_peer #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input wire logic pclk,
  // Lines
  input wire logic async_on,
  input wire logic tx_line,
  output logic rx_line,
  output logic sck_line
);
  logic [7:0] got_q [$];
  logic [7:0] b;
  // Idle line high, sync clock parked high between frames
  initial begin
    rx_line = 1'b1;
    sck_line = 1'b1;
  end
  // Monitor samples mid bit, first bit is the lsb
  initial begin
    forever begin
      @(negedge tx_line);
      repeat (BIT_CYC / 2) @(posedge pclk);
      if (async_on && tx_line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge pclk);
          b = {tx_line, b[7:1]};
        end
        repeat (BIT_CYC) @(posedge pclk);
        got_q.push_back(b);
      end
    end
  end
  task send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int k = 0; k < 10; k++) begin
      @(posedge pclk);
      rx_line <= f[k];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
  endtask : send_byte
  task sync_xfer(input logic [7:0] d, output logic [7:0] q);
    @(posedge pclk);
    for (int k = 0; k < 8; k++) begin
      sck_line <= 1'b0;
      rx_line <= d[k];
      repeat (4) @(posedge pclk);
      sck_line <= 1'b1;
      repeat (4) @(posedge pclk);
      // End of the high half: the pin moved three cycles after the fall
      q[k] = tx_line;
    end
    rx_line <= 1'b1;
  endtask : sync_xfer
endmodule : sadp_uart_peer
`default_nettype wire

// ---- verification/test_sadp_top.sv ----
// Self-checking bench for the serial data path
`timescale 1ns/1ps
`include "sadp_defs.svh"
`default_nettype none
module test_sadp_top;
  import sadp_pkg::*;
  logic pclk;
  logic presetn;
  sadp_apb_req_s apb_req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic standby_req;
  logic rx_pin;
  logic tx_pin;
  logic sck_in;
  logic sck_out;
  logic sck_oe;
  logic irq;
  logic async_on;
  logic [31:0] rdat;
  logic [7:0] got;
  logic err;
  int num_errors = 0;
  int check_count = 0;
  logic [15:0] idx_tab [10] = '{`SADP_IDX_PORTCTL, `SADP_IDX_MODE, `SADP_IDX_BAUD,
    `SADP_IDX_CTRL, `SADP_IDX_TXH, `SADP_IDX_STAT, `SADP_IDX_RXH, `SADP_IDX_CKGATE,
    `SADP_IDX_IRQST, `SADP_IDX_IRQMSK};
  logic [7:0] rst_tab [10] = '{8'hc0, 8'h00, 8'hff, 8'h00, 8'hff, 8'h84, 8'h00, 8'hff,
    8'h00, 8'h00};

  sadp_top i_sadp_top (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .standby_req(standby_req), .serial_rx_pin(rx_pin),
    .serial_tx_pin(tx_pin), .serial_clock_pin_in(sck_in), .serial_clock_pin_out(sck_out),
    .serial_clock_pin_oe(sck_oe), .irq(irq));
  sadp_uart_peer i_sadp_uart_peer (.pclk(pclk), .async_on(async_on), .tx_line(tx_pin),
    .rx_line(rx_pin), .sck_line(sck_in));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Request held until pready is sampled high
  task xfer(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, wd}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check({31'h0, pready}, 32'h1);
    rdat = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask : xfer
  task rd_chk(input logic [15:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    check(rdat, {24'h0, e});
  endtask : rd_chk
  task wait_stat(input int b);
    int n;
    n = 0;
    do begin
      xfer(1'b0, `SADP_IDX_STAT, 8'h00);
      n++;
    end while (rdat[b] !== 1'b1 && n < 200);
    check({31'h0, rdat[b]}, 32'h1);
  endtask : wait_stat
  task end_sim;
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Whole run is under two thousand cycles
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    apb_req = '0;
    standby_req = 1'b0;
    async_on = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd_chk(idx_tab[i], rst_tab[i]);
    end
    xfer(1'b0, 16'hffa0, 8'h00);
    check({31'h0, err}, 32'h1);
    xfer(1'b1, `SADP_IDX_RXH, 8'h5a);
    check({31'h0, err}, 32'h0);
    rd_chk(`SADP_IDX_RXH, 8'h00);
    xfer(1'b1, `SADP_IDX_MODE, 8'h80);
    rd_chk(`SADP_IDX_MODE, 8'h80);
    xfer(1'b1, `SADP_IDX_MODE, 8'h00);
    xfer(1'b1, `SADP_IDX_BAUD, 8'h00);
    xfer(1'b1, `SADP_IDX_TXH, 8'h3c);
    rd_chk(`SADP_IDX_TXH, 8'h3c);
    xfer(1'b1, `SADP_IDX_CTRL, 8'h30);
    wait_stat(`SADP_ST_TX_EMPTY_FLAG);
    xfer(1'b1, `SADP_IDX_TXH, 8'ha5);
    wait_stat(`SADP_ST_TEND);
    // Room for a stale second load to show up
    repeat (200) @(posedge pclk);
    check(32'(i_sadp_uart_peer.got_q.size()), 32'h2);
    check({24'h0, i_sadp_uart_peer.got_q[0]}, 32'h3c);
    check({24'h0, i_sadp_uart_peer.got_q[1]}, 32'ha5);
    xfer(1'b1, `SADP_IDX_MODE, 8'h40);
    xfer(1'b1, `SADP_IDX_TXH, 8'h00);
    wait_stat(`SADP_ST_TEND);
    repeat (40) @(posedge pclk);
    // Stop bit lands in the 8th data slot
    check({24'h0, i_sadp_uart_peer.got_q[2]}, 32'h80);
    xfer(1'b0, `SADP_IDX_IRQST, 8'h00);
    xfer(1'b1, `SADP_IDX_IRQMSK, 8'h02);
    xfer(1'b1, `SADP_IDX_MODE, 8'h08);
    fork
      begin
        i_sadp_uart_peer.send_byte(8'h96);
        i_sadp_uart_peer.send_byte(8'h69);
      end
      begin
        wait_stat(`SADP_ST_RDRF);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        rd_chk(`SADP_IDX_RXH, 8'h96);
        rd_chk(`SADP_IDX_IRQST, 8'h02);
        xfer(1'b1, `SADP_IDX_STAT, 8'h00);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
      end
    join
    wait_stat(`SADP_ST_RDRF);
    rd_chk(`SADP_IDX_RXH, 8'h69);
    rd_chk(`SADP_IDX_STAT, 8'hc4);
    // Seven data bits plus a wrong even parity bit in the 8th slot
    xfer(1'b1, `SADP_IDX_STAT, 8'h00);
    xfer(1'b1, `SADP_IDX_MODE, 8'h60);
    i_sadp_uart_peer.send_byte(8'h16);
    wait_stat(`SADP_ST_RDRF);
    rd_chk(`SADP_IDX_RXH, 8'h16);
    rd_chk(`SADP_IDX_STAT, 8'hcc);
    async_on <= 1'b0;
    xfer(1'b1, `SADP_IDX_CTRL, 8'h00);
    xfer(1'b1, `SADP_IDX_MODE, 8'hc0);
    rd_chk(`SADP_IDX_MODE, 8'hc0);
    check({31'h0, sck_oe}, 32'h1);
    check({31'h0, sck_out}, 32'h1);
    xfer(1'b1, `SADP_IDX_CTRL, 8'h32);
    rd_chk(`SADP_IDX_CTRL, 8'h32);
    check({31'h0, sck_oe}, 32'h0);
    xfer(1'b1, `SADP_IDX_STAT, 8'h00);
    xfer(1'b1, `SADP_IDX_TXH, 8'h5a);
    i_sadp_uart_peer.sync_xfer(8'hc3, got);
    check({24'h0, got}, 32'h5a);
    wait_stat(`SADP_ST_RDRF);
    rd_chk(`SADP_IDX_RXH, 8'hc3);
    standby_req <= 1'b1;
    repeat (3) @(posedge pclk);
    rd_chk(`SADP_IDX_MODE, 8'h00);
    rd_chk(`SADP_IDX_TXH, 8'hff);
    rd_chk(`SADP_IDX_RXH, 8'h00);
    standby_req <= 1'b0;
    end_sim();
  end
endmodule : test_sadp_top
`default_nettype wire
